//--- csml_subsys_end.sv
// subsystem end: register bank, queues and framing
module csml_subsys_end
  import csml_pkg::*;
#(
  parameter int DEPTH = CSML_QUEUE_DEPTH
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // register port, one transfer per cycle
  input wire logic sel_in,
  input wire logic write_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] rdata_out,
  output logic ready_out,
  output logic error_out,
  // interrupt
  output logic link_interrupt_out,
  // link
  csml_link_if.subsys link
);
  import csml_pkg::*;
  localparam int AW = $clog2(DEPTH);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] control_r;
  logic [7:0] mask_r;
  logic [7:0] last_byte_r;
  logic [31:0] last_word_r;
  logic in_win;
  logic [11:0] off;
  logic wr;
  logic rd;
  logic self_ret;
  logic enabled;
  logic word_mode;

  assign in_win = (addr_in >= CSML_BASE_ADDR) && (addr_in <= CSML_END_ADDR);
  assign off = addr_in[11:0];
  assign wr = sel_in && write_in && in_win;
  assign rd = sel_in && !write_in && in_win;
  assign ready_out = sel_in;
  assign error_out = sel_in && !in_win;
  assign self_ret = !control_r[CSML_CTL_SELF_RETURN_BIT];
  assign enabled = control_r[CSML_CTL_ENABLE_BIT];
  assign word_mode = control_r[CSML_CTL_WIDTH_BIT];

  // ---------------------------------------------------------------
  // transmit queue
  // ---------------------------------------------------------------
  logic [7:0] tx_mem [DEPTH];
  logic [DEPTH-1:0] tx_first;
  logic [AW:0] tx_wp_r;
  logic [AW:0] tx_rp_r;
  logic [AW:0] tx_cnt;
  // self_return_bit pops only into free receive space
  logic rx_room;
  logic tx_push;
  logic tx_ready;
  logic tx_pop;
  logic [AW:0] push_n;
  logic is_begin;
  logic [31:0] push_val;

  assign tx_cnt = tx_wp_r - tx_rp_r;
  assign push_n = word_mode ? (AW+1)'(4) : (AW+1)'(1);
  assign tx_ready = enabled &&
    ((AW+1)'(DEPTH) - tx_cnt >= push_n);
  assign is_begin = (off == CSML_OFF_BEGIN_BYTE) ||
    (off == CSML_OFF_BEGIN_WORD);
  assign tx_push = wr && tx_ready && (is_begin ||
    off == CSML_OFF_BYTE_PAY || off == CSML_OFF_WORD_PAY);
  assign push_val = wdata_in;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_wp_r <= '0;
      tx_first <= '0;
    end else if (tx_push) begin
      // writes while not ready are dropped; software polls first
      for (int i = 0; i < 4; i++) begin
        if (i < int'(push_n)) begin
          tx_mem[AW'(tx_wp_r + (AW+1)'(i))] <= push_val[8*i +: 8];
          tx_first[AW'(tx_wp_r + (AW+1)'(i))] <= is_begin && (i == 0);
        end
      end
      tx_wp_r <= tx_wp_r + push_n;
    end
  end

  assign link.req_valid = (tx_cnt != '0) && !self_ret;
  assign link.req_data = tx_mem[AW'(tx_rp_r)];
  assign link.req_first = tx_first[AW'(tx_rp_r)];
  assign tx_pop = (tx_cnt != '0) && (self_ret ? rx_room : link.req_ready);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_rp_r <= '0;
    end else if (tx_pop) begin
      tx_rp_r <= tx_rp_r + (AW+1)'(1);
    end
  end

  // ---------------------------------------------------------------
  // receive queue, fed by link or by self_return_bit
  // ---------------------------------------------------------------
  logic [7:0] rx_mem [DEPTH];
  logic [AW:0] rx_wp_r;
  logic [AW:0] rx_rp_r;
  logic [AW:0] rx_cnt;
  logic rx_push;
  logic [7:0] rx_in;
  logic rx_pop;
  logic rx_ready;

  assign rx_cnt = rx_wp_r - rx_rp_r;
  assign rx_room = rx_cnt != (AW+1)'(DEPTH);
  assign link.rsp_ready = rx_room && !self_ret;
  assign rx_push = self_ret ? tx_pop : (link.rsp_valid && rx_room);
  assign rx_in = self_ret ? tx_mem[AW'(tx_rp_r)] : link.rsp_data;
  assign rx_ready = rx_cnt != '0;
  assign rx_pop = rd && rx_ready && (off == CSML_OFF_BYTE_PAY);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_wp_r <= '0;
    end else if (rx_push) begin
      rx_mem[AW'(rx_wp_r)] <= rx_in;
      rx_wp_r <= rx_wp_r + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_rp_r <= '0;
    end else if (rx_pop) begin
      rx_rp_r <= rx_rp_r + (AW+1)'(1);
    end
  end

  // ---------------------------------------------------------------
  // control registers and read back
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      control_r <= CSML_CONTROL_RESET;
      mask_r <= CSML_MASK_RESET;
      last_byte_r <= 8'h00;
      last_word_r <= 32'h0000_0000;
    end else if (wr) begin
      if (off == CSML_OFF_CONTROL) control_r <= wdata_in[7:0];
      if (off == CSML_OFF_INT_MASK) mask_r <= wdata_in[7:0];
      if (off == CSML_OFF_BEGIN_BYTE) last_byte_r <= wdata_in[7:0];
      if (off == CSML_OFF_BEGIN_WORD) last_word_r <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (rd) begin
      unique case (off)
        CSML_OFF_CONTROL: rdata_out <= {24'h000000, control_r};
        CSML_OFF_STATUS: rdata_out <= {30'h00000000, rx_ready,
          tx_ready};
        CSML_OFF_INT_MASK: rdata_out <= {24'h000000, mask_r};
        CSML_OFF_BYTE_PAY: rdata_out <= {24'h000000, rx_mem[AW'(rx_rp_r)]};
        CSML_OFF_BEGIN_BYTE: rdata_out <= {24'h000000, last_byte_r};
        CSML_OFF_BEGIN_WORD: rdata_out <= last_word_r;
        default: rdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // one line to irq 19 in the processor
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      link_interrupt_out <= 1'b0;
    end else begin
      link_interrupt_out <= rx_ready &&
        mask_r[CSML_MASK_RX_READY_BIT];
    end
  end
endmodule

//--- csml_pkg.sv
// shared constants for the certificate service message link
package csml_pkg;
  // ---------------------------------------------------------------
  // register window and offsets
  // ---------------------------------------------------------------
  localparam logic [31:0] CSML_BASE_ADDR = 32'h4001_6000;
  localparam logic [31:0] CSML_END_ADDR = 32'h4001_6fff;
  localparam logic [11:0] CSML_OFF_CONTROL = 12'h000;
  localparam logic [11:0] CSML_OFF_STATUS = 12'h004;
  localparam logic [11:0] CSML_OFF_INT_MASK = 12'h008;
  localparam logic [11:0] CSML_OFF_BYTE_PAY = 12'h010;
  localparam logic [11:0] CSML_OFF_WORD_PAY = 12'h014;
  localparam logic [11:0] CSML_OFF_BEGIN_BYTE = 12'h018;
  localparam logic [11:0] CSML_OFF_BEGIN_WORD = 12'h01c;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CSML_CTL_WIDTH_BIT = 2;
  localparam int CSML_CTL_ENABLE_BIT = 4;
  localparam int CSML_CTL_SELF_RETURN_BIT = 5;
  localparam int CSML_STAT_TX_READY_BIT = 0;
  localparam int CSML_STAT_RX_READY_BIT = 1;
  localparam int CSML_MASK_RX_READY_BIT = 1;
  localparam logic [7:0] CSML_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CSML_MASK_RESET = 8'h00;
  localparam int CSML_QUEUE_DEPTH = 8;
  // ---------------------------------------------------------------
  // service framing
  // ---------------------------------------------------------------
  localparam logic [7:0] CSML_CMD_CERT = 8'h00;
  localparam logic [7:0] CSML_STATUS_OK = 8'h00;
  localparam int CSML_CERT_BYTES = 768;
  localparam int CSML_ISSUER_ID_BYTES = 9;
  localparam int CSML_REQ_BYTES = 5;
  localparam int CSML_RSP_BYTES = 6;
endpackage

//--- csml_link_if.sv
// byte stream link between subsystem end and controller end
interface csml_link_if;
  logic [7:0] req_data;
  logic req_valid;
  logic req_first;
  logic req_ready;
  logic [7:0] rsp_data;
  logic rsp_valid;
  logic rsp_first;
  logic rsp_ready;
  modport subsys (output req_data, output req_valid, output req_first,
    input req_ready, input rsp_data, input rsp_valid, input rsp_first,
    output rsp_ready);
  modport ctrl (input req_data, input req_valid, input req_first,
    output req_ready, output rsp_data, output rsp_valid,
    output rsp_first, input rsp_ready);
endinterface

//--- csml_ctrl_end.sv
// controller end: runs the certificate service and replies
module csml_ctrl_end
  import csml_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // link
  csml_link_if.ctrl link,
  // certificate memory write port
  output logic mem_we_out,
  output logic [31:0] mem_addr_out,
  output logic [7:0] mem_data_out,
  // certificate source byte, indexed by mem_idx_out
  output logic [9:0] mem_idx_out,
  input wire logic [7:0] cert_byte_in,
  // issuer identifier length, fixed
  output logic [3:0] issuer_id_len_out
);
  import csml_pkg::*;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CS_RECV = 4'b0001, CS_WRITE = 4'b0010, CS_REPLY = 4'b0100,
    CS_SPARE = 4'b1000
  } csml_cs_t;
  csml_cs_t state_r;
  logic [2:0] cnt_r;
  logic [7:0] cmd_r;
  logic [31:0] ptr_r;
  logic [9:0] idx_r;
  logic [7:0] rsp_byte;

  assign issuer_id_len_out = 4'(CSML_ISSUER_ID_BYTES);
  assign link.req_ready = (state_r == CS_RECV);
  assign link.rsp_valid = (state_r == CS_REPLY);
  assign link.rsp_first = (state_r == CS_REPLY) && (cnt_r == 3'h0);
  assign mem_idx_out = idx_r;

  // reply layout: echo, status, pointer lsb first
  always_comb begin
    unique case (cnt_r)
      3'h0: rsp_byte = cmd_r;
      3'h1: rsp_byte = CSML_STATUS_OK;
      3'h2: rsp_byte = ptr_r[7:0];
      3'h3: rsp_byte = ptr_r[15:8];
      3'h4: rsp_byte = ptr_r[23:16];
      default: rsp_byte = ptr_r[31:24];
    endcase
  end
  assign link.rsp_data = rsp_byte;

  // ---------------------------------------------------------------
  // service sequence
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r <= CS_RECV;
      cnt_r <= 3'h0;
      cmd_r <= 8'h00;
      ptr_r <= 32'h0000_0000;
      idx_r <= 10'h000;
    end else begin
      unique case (state_r)
        CS_RECV: if (link.req_valid) begin
          // a new frame start always resyncs the parser
          if (link.req_first) begin
            cmd_r <= link.req_data;
            cnt_r <= 3'h1;
          end else if (cnt_r != 3'h0) begin
            ptr_r <= {link.req_data, ptr_r[31:8]};
            if (cnt_r == 3'(CSML_REQ_BYTES - 1)) begin
              cnt_r <= 3'h0;
              idx_r <= 10'h000;
              state_r <= CS_WRITE;
            end else begin
              cnt_r <= cnt_r + 3'h1;
            end
          end
        end
        CS_WRITE: begin
          if (idx_r == 10'(CSML_CERT_BYTES - 1)) begin
            state_r <= CS_REPLY;
          end
          idx_r <= idx_r + 10'h001;
        end
        CS_REPLY: if (link.rsp_ready) begin
          if (cnt_r == 3'(CSML_RSP_BYTES - 1)) begin
            cnt_r <= 3'h0;
            state_r <= CS_RECV;
          end else begin
            cnt_r <= cnt_r + 3'h1;
          end
        end
        default: state_r <= CS_RECV;
      endcase
    end
  end

  // certificate write data from flops
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      mem_we_out <= 1'b0;
      mem_addr_out <= 32'h0000_0000;
      mem_data_out <= 8'h00;
    end else begin
      mem_we_out <= (state_r == CS_WRITE);
      mem_addr_out <= ptr_r + {22'h000000, idx_r};
      mem_data_out <= cert_byte_in;
    end
  end
endmodule

//--- csml_link_chk.sv
// link-side checker for the message link
module csml_link_chk
  import csml_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // link signals
  input wire logic [7:0] req_data,
  input wire logic req_valid,
  input wire logic req_first,
  input wire logic req_ready,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_valid,
  input wire logic rsp_first,
  input wire logic rsp_ready
);
  import csml_pkg::*;
  // ---------------------------------------------------------------
  // frame positions and captured pointer
  // ---------------------------------------------------------------
  logic [3:0] req_cnt_r;
  logic [3:0] rsp_cnt_r;
  logic [31:0] ptr_r;
  wire req_hs = req_valid && req_ready;
  wire rsp_hs = rsp_valid && rsp_ready;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      req_cnt_r <= 4'h0;
    end else if (req_hs) begin
      req_cnt_r <= req_first ? 4'h1 : req_cnt_r + 4'h1;
    end
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rsp_cnt_r <= 4'h0;
    end else if (rsp_hs) begin
      rsp_cnt_r <= rsp_first ? 4'h1 : rsp_cnt_r + 4'h1;
    end
  end
  // pointer kept lsb first, as it crosses
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ptr_r <= 32'h0;
    end else if (req_hs && !req_first && req_cnt_r inside {[1:4]}) begin
      ptr_r[8*(req_cnt_r-4'h1) +: 8] <= req_data;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  a_req_hold_stable: assert property (req_valid && !req_ready |=>
    req_valid && $stable(req_data)) else $error("request byte dropped");
  a_rsp_hold_stable: assert property (rsp_valid && !rsp_ready |=>
    rsp_valid && $stable(rsp_data)) else $error("reply byte dropped");
  a_reply_echo_cmd: assert property (rsp_valid && rsp_first |->
    rsp_data == CSML_CMD_CERT) else $error("reply echo wrong");
  a_reply_status_ok: assert property (rsp_valid && !rsp_first &&
    rsp_cnt_r == 4'h1 |-> rsp_data == CSML_STATUS_OK)
    else $error("reply status wrong");
  a_reply_ptr_echo: assert property (rsp_valid && !rsp_first &&
    rsp_cnt_r inside {[2:5]} |-> rsp_data == ptr_r[8*(rsp_cnt_r-4'h2) +: 8])
    else $error("reply pointer differs");
  a_reply_frame_len: assert property (rsp_valid && rsp_first |->
    rsp_cnt_r == 4'h0 || rsp_cnt_r == 4'h6) else $error("reply length");
  a_reply_no_extra: assert property (rsp_valid && !rsp_first |->
    rsp_cnt_r inside {[1:5]}) else $error("reply byte outside frame");
  a_req_frame_layout: assert property (req_valid && !req_first |->
    req_cnt_r inside {[1:4]}) else $error("request byte outside frame");
  a_reply_in_time: assert property (req_hs && !req_first &&
    req_cnt_r == 4'h4 |-> ##[1:1000] (rsp_valid && rsp_first))
    else $error("no reply after request");
  c_request: cover property (req_hs && req_first);
  c_reply: cover property (rsp_hs && rsp_first);
  c_reply_stall: cover property (rsp_valid && !rsp_ready);
endmodule

//--- tb_top.sv
// self-checking bench for both ends of the message link
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import csml_pkg::*;
  typedef struct {
    logic w;
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } csml_row_t;
  localparam logic [31:0] PTR = 32'h2000_0104;
  localparam logic [31:0] B = CSML_BASE_ADDR;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic sel_in = 1'b0;
  logic write_in = 1'b0;
  logic [31:0] addr_in = 32'h0;
  logic [31:0] wdata_in = 32'h0;
  logic [31:0] rdata_out;
  logic ready_out;
  logic error_out;
  logic link_interrupt_out;
  logic mem_we_out;
  logic [31:0] mem_addr_out;
  logic [7:0] mem_data_out;
  logic [9:0] mem_idx_out;
  logic [3:0] issuer_id_len_out;
  logic [7:0] cert_byte_in;
  logic [31:0] rd;
  logic er;
  logic rdy;
  int n_errors = 0;
  int comparisons = 0;
  int n_mem = 0;
  int i;
  // ---------------------------------------------------------------
  // ordinary register cases
  // ---------------------------------------------------------------
  csml_row_t rows [7] = '{
    '{1'b0, B, 32'h0, 32'h0, 1'b0},
    '{1'b0, B + 32'h8, 32'h0, 32'h0, 1'b0},
    '{1'b1, B, 32'h10, 32'h0, 1'b0},
    '{1'b0, B, 32'h0, 32'h10, 1'b0},
    '{1'b1, B + 32'h1000, 32'h5, 32'h0, 1'b1},
    '{1'b0, B - 32'h4, 32'h0, 32'h0, 1'b1},
    '{1'b0, B + 32'h14, 32'h0, 32'h0, 1'b0}};
  csml_link_if link ();
  csml_subsys_end #(.DEPTH(CSML_QUEUE_DEPTH)) i_csml_subsys_end (
    .clk_in(clk_in), .reset_in(reset_in), .sel_in(sel_in),
    .write_in(write_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .rdata_out(rdata_out), .ready_out(ready_out), .error_out(error_out),
    .link_interrupt_out(link_interrupt_out), .link(link));
  csml_ctrl_end i_csml_ctrl_end (
    .clk_in(clk_in), .reset_in(reset_in), .link(link),
    .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
    .mem_data_out(mem_data_out), .mem_idx_out(mem_idx_out),
    .cert_byte_in(cert_byte_in), .issuer_id_len_out(issuer_id_len_out));
  csml_link_chk i_csml_link_chk (
    .clk_in(clk_in), .reset_in(reset_in), .req_data(link.req_data),
    .req_valid(link.req_valid), .req_first(link.req_first),
    .req_ready(link.req_ready), .rsp_data(link.rsp_data),
    .rsp_valid(link.rsp_valid), .rsp_first(link.rsp_first),
    .rsp_ready(link.rsp_ready));
  // certificate source: a pattern that differs from its index
  assign cert_byte_in = mem_idx_out[7:0] ^ 8'ha5;
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one access; error and registered read data both sampled at the next falling edge, still selected
  task automatic bus(input logic w, input logic [31:0] a,
      input logic [31:0] d);
    @(negedge clk_in);
    sel_in = 1'b1;
    write_in = w;
    addr_in = a;
    wdata_in = d;
    @(negedge clk_in);
    er = error_out;
    rdy = ready_out;
    rd = rdata_out;
    sel_in = 1'b0;
  endtask
  task automatic rdc(input logic [11:0] o, input logic [31:0] exp);
    bus(1'b0, B + {20'h0, o}, 32'h0);
    chk(rd, exp);
  endtask
  task automatic poll(input int b, input logic v);
    for (i = 0; i < 100; i++) begin
      bus(1'b0, B + {20'h0, CSML_OFF_STATUS}, 32'h0);
      if (rd[b] === v) break;
    end
    if (i == 100) begin
      chk(rd, 32'(v) << b);
      report_and_stop();
    end
  endtask
  // sampled on the falling edge, clear of the launching edge
  always @(negedge clk_in) begin
    if (mem_we_out === 1'b1) begin
      chk(mem_addr_out, PTR + 32'(n_mem % CSML_CERT_BYTES));
      chk({24'h0, mem_data_out}, {24'h0, 8'(n_mem) ^ 8'ha5});
      n_mem++;
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    @(negedge clk_in);
    reset_in = 1'b0;
    for (int k = 0; k < 7; k++) begin
      bus(rows[k].w, rows[k].a, rows[k].d);
      chk({31'h0, er}, {31'h0, rows[k].e});
      chk({31'h0, rdy}, 32'h1);
      if (!rows[k].w && !rows[k].e) begin
        chk(rd, rows[k].x);
      end
    end
    // self_return_bit with the interrupt masked, then unmasked
    poll(CSML_STAT_TX_READY_BIT, 1'b1);
    bus(1'b1, B + 32'h10, 32'h5a);
    poll(CSML_STAT_RX_READY_BIT, 1'b1);
    chk({31'h0, link_interrupt_out}, 32'h0);
    bus(1'b1, B + 32'h8, 32'h2);
    @(negedge clk_in);
    chk({31'h0, link_interrupt_out}, 32'h1);
    rdc(CSML_OFF_BYTE_PAY, 32'h5a);
    // interrupt is registered: it falls one edge after the pop
    @(negedge clk_in);
    chk({31'h0, link_interrupt_out}, 32'h0);
    // word frame start in byte width loops back its low byte only
    bus(1'b1, B + 32'h1c, 32'h1234_56c3);
    rdc(CSML_OFF_BEGIN_WORD, 32'h1234_56c3);
    rdc(CSML_OFF_BYTE_PAY, 32'hc3);
    // two requests; the second queues while the first is served
    for (int r = 0; r < 2; r++) begin
      bus(1'b1, B, 32'h30);
      poll(CSML_STAT_TX_READY_BIT, 1'b1);
      bus(1'b1, B + 32'h18, {24'h0, CSML_CMD_CERT});
      bus(1'b1, B, 32'h34);
      poll(CSML_STAT_TX_READY_BIT, 1'b1);
      bus(1'b1, B + 32'h14, PTR);
    end
    // five queued bytes leave no room for another word
    rdc(CSML_OFF_STATUS, 32'h0);
    for (int r = 1; r < 3; r++) begin
      for (i = 0; i < 2000 && link_interrupt_out !== 1'b1; i++) begin
        @(negedge clk_in);
      end
      chk({31'h0, link_interrupt_out}, 32'h1);
      if (i == 2000) begin
        report_and_stop();
      end
      chk(32'(n_mem), 32'(CSML_CERT_BYTES * r));
      rdc(CSML_OFF_BYTE_PAY, {24'h0, CSML_CMD_CERT});
      rdc(CSML_OFF_BYTE_PAY, {24'h0, CSML_STATUS_OK});
      for (int k = 0; k < 4; k++) begin
        rdc(CSML_OFF_BYTE_PAY, (PTR >> (8 * k)) & 32'hff);
      end
      @(negedge clk_in);
      chk({31'h0, link_interrupt_out}, 32'h0);
    end
    chk({28'h0, issuer_id_len_out}, 32'h9);
    // reset in mid-run returns the registers to their reset values
    @(negedge clk_in);
    reset_in = 1'b1;
    @(negedge clk_in);
    reset_in = 1'b0;
    rdc(CSML_OFF_CONTROL, 32'h0);
    rdc(CSML_OFF_INT_MASK, 32'h0);
    rdc(CSML_OFF_STATUS, 32'h0);
    report_and_stop();
  end
endmodule
